// >>> core/owd_top.sv
// Purpose: Enable, startup sequencing and one-wire brightness receiver
// Assumes: Pins are asynchronous to clk; analog parts sit outside
// Notes: Code output feeds the sink current DAC (current = code/511 of full scale)
`timescale 1ns/100ps
module owd_top
	import owd_pkg::*;
#(
	parameter int unsigned EN_OFF_CYC_P = owd_pkg::EN_OFF_CYC,
	parameter int unsigned DUTY_OFF_CYC_P = owd_pkg::DUTY_OFF_CYC,
	parameter int unsigned REDUCED_LIMIT_CYC_P = owd_pkg::REDUCED_LIMIT_CYC,
	parameter int unsigned SELECT_WAIT_CYC_P = owd_pkg::SELECT_WAIT_CYC,
	parameter int unsigned SELECT_LOW_CYC_P = owd_pkg::SELECT_LOW_CYC,
	parameter int unsigned SELECT_WINDOW_CYC_P = owd_pkg::SELECT_WINDOW_CYC,
	parameter int unsigned BIT_MAX_CYC_P = owd_pkg::BIT_MAX_CYC,
	parameter int unsigned ACK_CYC_P = owd_pkg::ACK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and sensed levels
	input wire logic supply_lockout,
	input wire logic ctrl_line_in,
	input wire logic duty_in,
	input wire logic [1:0] sink_feedback_pin_gnd,
	// Open-drain acknowledge on the control line
	output logic ctrl_line_out,
	output logic ctrl_line_oe,
	// Startup and regulation status
	output logic device_on,
	output logic onewire_mode,
	output logic [1:0] chan_enable,
	output logic switching_on,
	output logic reduced_peak_limit,
	// Brightness
	output logic [owd_pkg::CODE_W-1:0] brightness_code,
	output logic cmd_accepted
);
	import owd_pkg::*;

	// ==========================================
	// Register set
	typedef struct packed {
		logic [N_IN-1:0] s1; // First sync stage
		logic [N_IN-1:0] s2;
		logic [N_IN-1:0] s3;
		logic [N_IN-1:0] lvl; // Filtered pin levels
		owd_state_t st;
		logic [TMR_W-1:0] tmr; // Window and soft start timer
		logic [TMR_W-1:0] en_lo; // Control line low time
		logic [TMR_W-1:0] dt_lo; // Duty input low time
		logic [TMR_W-1:0] sel_lo; // Selection low run
		logic onew;
		logic [CODE_W-1:0] code;
		logic [1:0] chan;
		logic sw;
		logic lim;
		owd_rx_t rx;
		logic [PH_W-1:0] ph; // Phase length counter
		logic [PH_W-1:0] lo_len; // Low phase of current bit
		logic [CMD_BITS-1:0] sh; // Command shift register
		logic [4:0] nbits;
		logic ack_oe;
		logic drv;
		logic ok;
		logic on; // Device on, kept in a flop so the port has no decode glitch
	} owd_regs_t;

	localparam owd_regs_t Q_RST = '{s1: IN_RESET, s2: IN_RESET, s3: IN_RESET, lvl: IN_RESET,
		st: ST_OFF, tmr: '0, en_lo: '0, dt_lo: '0, sel_lo: '0, onew: 1'b0, code: CODE_DEFAULT,
		chan: 2'h0, sw: 1'b0, lim: 1'b0, rx: RX_IDLE, ph: '0, lo_len: '0, sh: '0, nbits: 5'h00,
		ack_oe: 1'b0, drv: 1'b0, ok: 1'b0, on: 1'b0};

	owd_regs_t q_ff; // Registered state
	owd_regs_t nxt_q; // Next state
	logic [1:0] rst_sync_ff; // Reset release chain
	logic rst_core_n; // Synchronised reset
	logic [N_IN-1:0] agree; // Stages two and three match
	logic ctrl_fall;
	logic ctrl_rise;
	logic kill; // Shutdown request
	logic rx_on; // Receiver allowed
	logic take; // Bit decided this cycle
	logic bit_val;
	logic [CMD_BITS-1:0] word; // Shift value after a bit

	// ==========================================
	// Reset release
	// Asserts at once, releases two edges later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_ff[1];

	// ==========================================
	// Next state
	always_comb begin
		nxt_q = q_ff;
		nxt_q.ok = 1'b0;
		take = 1'b0;
		bit_val = 1'b0;
		word = q_ff.sh;

		// Three stage sync, level moves when stages two and three agree
		nxt_q.s1 = {sink_feedback_pin_gnd, duty_in, ctrl_line_in, supply_lockout};
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		agree = ~(q_ff.s2 ^ q_ff.s3);
		nxt_q.lvl = (agree & q_ff.s3) | (~agree & q_ff.lvl);
		ctrl_fall = q_ff.lvl[IN_CTRL] & ~nxt_q.lvl[IN_CTRL];
		ctrl_rise = ~q_ff.lvl[IN_CTRL] & nxt_q.lvl[IN_CTRL];

		// Low time counters, saturate just past their limit
		if (q_ff.lvl[IN_CTRL]) begin
			nxt_q.en_lo = '0;
		end else if (q_ff.en_lo <= TMR_W'(EN_OFF_CYC_P)) begin
			nxt_q.en_lo = q_ff.en_lo + 1'b1;
		end
		if (q_ff.lvl[IN_DUTY]) begin
			nxt_q.dt_lo = '0;
		end else if (q_ff.dt_lo <= TMR_W'(DUTY_OFF_CYC_P)) begin
			nxt_q.dt_lo = q_ff.dt_lo + 1'b1;
		end

		// Either line's timeout or lockout forces shutdown
		kill = q_ff.lvl[IN_LOCKOUT]
			| (~q_ff.lvl[IN_CTRL] & (q_ff.en_lo > TMR_W'(EN_OFF_CYC_P)))
			| (~q_ff.lvl[IN_DUTY] & (q_ff.dt_lo > TMR_W'(DUTY_OFF_CYC_P)));

		// Startup sequence
		case (q_ff.st)
			ST_OFF: begin
				// All three conditions needed to leave shutdown
				if (~q_ff.lvl[IN_LOCKOUT] & q_ff.lvl[IN_CTRL] & q_ff.lvl[IN_DUTY]) begin
					nxt_q.st = ST_DETECT;
					nxt_q.tmr = '0;
					nxt_q.sel_lo = '0;
				end
			end
			ST_DETECT: begin
				// Window opens on entry to this state, once all three start conditions hold
				nxt_q.tmr = q_ff.tmr + 1'b1;
				if (~q_ff.lvl[IN_CTRL] & (q_ff.tmr >= TMR_W'(SELECT_WAIT_CYC_P))) begin
					nxt_q.sel_lo = q_ff.sel_lo + 1'b1;
				end else begin
					nxt_q.sel_lo = '0;
				end
				// Low run long enough inside the window selects one-wire
				if ((q_ff.sel_lo > TMR_W'(SELECT_LOW_CYC_P)) & (q_ff.tmr < TMR_W'(SELECT_WINDOW_CYC_P))) begin
					nxt_q.onew = 1'b1;
				end
				// Without the pattern, duty-input dimming stays selected
				if (q_ff.tmr >= TMR_W'(SELECT_WINDOW_CYC_P)) begin
					nxt_q.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// Grounded sinks leave regulation before soft start
				nxt_q.chan = ~q_ff.lvl[IN_FB1:IN_FB0];
				if (&q_ff.lvl[IN_FB1:IN_FB0]) begin
					nxt_q.st = ST_HALT;
				end else begin
					nxt_q.st = ST_SOFT;
					nxt_q.tmr = '0;
					nxt_q.sw = 1'b1;
					nxt_q.lim = 1'b1;
				end
			end
			ST_SOFT: begin
				// Reduced limit for the first part of switching
				nxt_q.tmr = q_ff.tmr + 1'b1;
				if (q_ff.tmr >= TMR_W'(REDUCED_LIMIT_CYC_P - 1)) begin
					nxt_q.st = ST_RUN;
					nxt_q.lim = 1'b0;
				end
			end
			ST_RUN: begin
				// Regulating; only shutdown leaves
				nxt_q.st = ST_RUN;
			end
			ST_HALT: begin
				// Both channels unusable, stay off until shutdown
				nxt_q.chan = 2'h0;
				nxt_q.code = CODE_DEFAULT;
			end
			default: begin
				nxt_q.st = ST_OFF;
			end
		endcase

		// ==========================================
		// One-wire receiver
		// Only once one-wire is selected and the sinks are checked
		rx_on = q_ff.onew & ((q_ff.st == ST_SOFT) | (q_ff.st == ST_RUN));
		if (rx_on) begin
			case (q_ff.rx)
				RX_IDLE: begin
					// Line high between bits; a long high drops a partial frame
					if (ctrl_fall) begin
						nxt_q.rx = RX_LOW;
						nxt_q.ph = '0;
					end else if (q_ff.nbits != 5'h00) begin
						nxt_q.ph = q_ff.ph + 1'b1;
						if (q_ff.ph >= PH_W'(BIT_MAX_CYC_P)) begin
							nxt_q.nbits = 5'h00;
							nxt_q.ph = '0;
						end
					end
				end
				RX_LOW: begin
					// Measure the low phase of the bit
					if (ctrl_rise) begin
						nxt_q.rx = RX_HIGH;
						nxt_q.lo_len = q_ff.ph;
						nxt_q.ph = '0;
					end else if (q_ff.ph >= PH_W'(BIT_MAX_CYC_P)) begin
						// Slower than the lowest rate: not a bit
						nxt_q.nbits = 5'h00;
						nxt_q.rx = RX_EOF;
					end else begin
						nxt_q.ph = q_ff.ph + 1'b1;
					end
				end
				RX_HIGH: begin
					// Ratio of the two phases gives the value, whatever the rate
					if (ctrl_fall) begin
						take = 1'b1;
						bit_val = 1'b0;
						nxt_q.rx = RX_LOW;
						nxt_q.ph = '0;
					end else if (q_ff.ph >= q_ff.lo_len) begin
						take = 1'b1;
						bit_val = 1'b1;
						nxt_q.rx = RX_IDLE;
						nxt_q.ph = '0;
					end else begin
						nxt_q.ph = q_ff.ph + 1'b1;
					end
				end
				RX_EOF: begin
					// Wait for the line to return high
					if (q_ff.lvl[IN_CTRL] & ~ctrl_fall) begin
						nxt_q.rx = RX_IDLE;
						nxt_q.ph = '0;
					end
				end
				RX_ACK: begin
					// Hold the line low for the acknowledge time
					nxt_q.ph = q_ff.ph + 1'b1;
					if (q_ff.ph >= PH_W'(ACK_CYC_P - 1)) begin
						nxt_q.ack_oe = 1'b0;
						nxt_q.rx = RX_EOF;
					end
				end
				default: begin
					nxt_q.rx = RX_IDLE;
				end
			endcase

			// New bit enters at the top so the first bit ends at bit 0
			if (take) begin
				word = {bit_val, q_ff.sh[CMD_BITS-1:1]};
				nxt_q.sh = word;
				if (q_ff.nbits == LAST_BIT) begin
					nxt_q.nbits = 5'h00;
					// A final zero bit ends on a low; let it finish
					nxt_q.rx = bit_val ? RX_IDLE : RX_EOF;
					if (word[ADDR_LSB +: ADDR_W] == TARGET_ADDRESS_BYTE) begin
						// Unused bits ignored; any value taken
						nxt_q.code = word[CODE_LSB +: CODE_W];
						nxt_q.ok = 1'b1;
						if (word[ACK_REQ_POS]) begin
							nxt_q.rx = RX_ACK;
							nxt_q.ack_oe = 1'b1;
							nxt_q.ph = '0;
						end
					end
				end else begin
					nxt_q.nbits = q_ff.nbits + 1'b1;
				end
			end
		end else begin
			// Receiver parked; any partial frame is lost
			nxt_q.rx = RX_IDLE;
			nxt_q.nbits = 5'h00;
			nxt_q.ph = '0;
			nxt_q.ack_oe = 1'b0;
		end

		// Shutdown clears state, mode, code, channels, switching, limit and receiver control
		if (kill) begin
			nxt_q.st = ST_OFF;
			nxt_q.onew = 1'b0;
			nxt_q.code = CODE_DEFAULT;
			nxt_q.chan = 2'h0;
			nxt_q.sw = 1'b0;
			nxt_q.lim = 1'b0;
			nxt_q.rx = RX_IDLE;
			nxt_q.nbits = 5'h00;
			nxt_q.ack_oe = 1'b0;
			nxt_q.ok = 1'b0;
		end
		nxt_q.drv = 1'b0; // Open drain only ever pulls low
		// On in every state but shutdown and halt, taken from the next state
		nxt_q.on = (nxt_q.st != ST_OFF) & (nxt_q.st != ST_HALT);
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			q_ff <= Q_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ==========================================
	// Outputs, all straight from the register
	assign ctrl_line_out = q_ff.drv;
	assign ctrl_line_oe = q_ff.ack_oe;
	assign device_on = q_ff.on;
	assign onewire_mode = q_ff.onew;
	assign chan_enable = q_ff.chan;
	assign switching_on = q_ff.sw;
	assign reduced_peak_limit = q_ff.lim;
	// Sink DAC scales full-scale current by this code over 511
	assign brightness_code = q_ff.code;
	assign cmd_accepted = q_ff.ok;
endmodule

// >>> core/owd_pkg.sv
// Purpose: Shared constants and types of the one-wire dimming control block
// Assumes: 100 MHz core clock
// Notes: Times are in ns, cycle counts are derived from them
package owd_pkg;
	// ==========================================
	// Clock and times
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned EN_OFF_TIME_NS = 2500000; // Control line low
	localparam int unsigned DUTY_OFF_TIME_NS = 20000000; // Duty input low
	localparam int unsigned REDUCED_LIMIT_DURATION_NS = 5000000;
	localparam int unsigned SELECT_WAIT_TIME_NS = 100000;
	localparam int unsigned SELECT_LOW_TIME_NS = 260000;
	localparam int unsigned SELECT_WINDOW_TIME_NS = 1000000;
	localparam int unsigned BIT_MAX_TIME_NS = 588235; // One bit at 1.7 kbit/s
	localparam int unsigned ACK_TIME_NS = 400000; // Acknowledge low time

	// ==========================================
	// Cycle counts (least times round up, longest round down)
	localparam int unsigned EN_OFF_CYC = (EN_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DUTY_OFF_CYC = (DUTY_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REDUCED_LIMIT_CYC = REDUCED_LIMIT_DURATION_NS / CLK_PERIOD_NS;
	localparam int unsigned SELECT_WAIT_CYC = (SELECT_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SELECT_LOW_CYC = (SELECT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SELECT_WINDOW_CYC = SELECT_WINDOW_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned BIT_MAX_CYC = BIT_MAX_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned ACK_CYC = ACK_TIME_NS / CLK_PERIOD_NS;

	// ==========================================
	// Widths and pin input slots
	localparam int TMR_W = 32;
	localparam int PH_W = 20;
	localparam int N_IN = 5;
	localparam int IN_LOCKOUT = 0;
	localparam int IN_CTRL = 1;
	localparam int IN_DUTY = 2;
	localparam int IN_FB0 = 3;
	localparam int IN_FB1 = 4;
	localparam logic [N_IN-1:0] IN_RESET = 5'h01; // Lockout asserted, rest low

	// ==========================================
	// Command layout, received word is {data, address}
	localparam int CMD_BITS = 24;
	localparam int ADDR_W = 8;
	localparam int ADDR_LSB = 0;
	localparam int DATA_LSB = 8;
	localparam int ACK_REQ_POS = DATA_LSB + 10;
	localparam int CODE_W = 9;
	localparam int CODE_LSB = DATA_LSB;
	localparam logic [ADDR_W-1:0] TARGET_ADDRESS_BYTE = 8'h8F;
	localparam logic [CODE_W-1:0] CODE_DEFAULT = 9'h1FF;
	localparam logic [4:0] LAST_BIT = 5'h17;

	// ==========================================
	// State types
	typedef enum logic [2:0] {ST_OFF, ST_DETECT, ST_CHECK, ST_SOFT, ST_RUN, ST_HALT} owd_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_LOW, RX_HIGH, RX_EOF, RX_ACK} owd_rx_t;
endpackage

// >>> tb/owd_assertions.sv
// Purpose: Port checks of owd_top
// Assumes: Counts match the bound top
// Notes: Bound to every owd_top
`timescale 1ns/100ps
module owd_assertions
	import owd_pkg::*;
#(
	parameter int unsigned REDUCED_LIMIT_CYC_P = 100,
	parameter int unsigned ACK_CYC_P = 30
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic [1:0] sink_feedback_pin_gnd,
	input wire logic ctrl_line_out,
	input wire logic ctrl_line_oe,
	// Status and code
	input wire logic device_on,
	input wire logic onewire_mode,
	input wire logic [1:0] chan_enable,
	input wire logic switching_on,
	input wire logic reduced_peak_limit,
	input wire logic [owd_pkg::CODE_W-1:0] brightness_code,
	input wire logic cmd_accepted
);
	int lim_cnt_ff; // High cycles of reduced limit
	int oe_cnt_ff; // High cycles of acknowledge drive
	// ====================
	// Helper counter, too long for a repetition
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lim_cnt_ff <= 0;
			oe_cnt_ff <= 0;
		end else begin
			lim_cnt_ff <= reduced_peak_limit ? lim_cnt_ff + 1 : 0;
			oe_cnt_ff <= ctrl_line_oe ? oe_cnt_ff + 1 : 0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ====================
	// Properties
	property p_od; ctrl_line_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("ack pin drives high");
	property p_off; !device_on [*2] |-> brightness_code == 9'h1FF && !onewire_mode && !switching_on; endproperty
	a_off: assert property (p_off) else $error("state kept while off");
	property p_lim_start; $rose(switching_on) |-> reduced_peak_limit && chan_enable != 2'h0; endproperty
	a_lim_start: assert property (p_lim_start) else $error("soft start wrong");
	property p_lim_end; $fell(reduced_peak_limit) && switching_on |-> lim_cnt_ff == REDUCED_LIMIT_CYC_P; endproperty
	a_lim_end: assert property (p_lim_end) else $error("limit time wrong");
	property p_chan; switching_on |-> (chan_enable & sink_feedback_pin_gnd) == 2'h0; endproperty
	a_chan: assert property (p_chan) else $error("grounded sink on");
	property p_window; $rose(device_on) |-> !switching_on [*8]; endproperty
	a_window: assert property (p_window) else $error("no window");
	property p_acc; cmd_accepted |-> device_on && onewire_mode; endproperty
	a_acc: assert property (p_acc) else $error("accept outside mode");
	property p_load; $changed(brightness_code) && device_on |-> ##[0:1] cmd_accepted; endproperty
	a_load: assert property (p_load) else $error("code moved alone");
	property p_ack; $rose(ctrl_line_oe) |-> cmd_accepted; endproperty
	a_ack: assert property (p_ack) else $error("ack wrong");
	// Ack length by counter, the real count is far beyond a plain delay
	property p_ack_len; $fell(ctrl_line_oe) && device_on |-> oe_cnt_ff == ACK_CYC_P; endproperty
	a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
	c_ack: cover property (cmd_accepted && ctrl_line_oe);
	c_lim: cover property ($fell(reduced_peak_limit));
	c_mode: cover property ($rose(onewire_mode));
endmodule
bind owd_top owd_assertions #(.REDUCED_LIMIT_CYC_P(REDUCED_LIMIT_CYC_P), .ACK_CYC_P(ACK_CYC_P)) i_owd_assertions (
	.clk(clk), .rst_n(rst_n), .sink_feedback_pin_gnd(sink_feedback_pin_gnd), .ctrl_line_out(ctrl_line_out),
	.ctrl_line_oe(ctrl_line_oe), .device_on(device_on), .onewire_mode(onewire_mode), .chan_enable(chan_enable),
	.switching_on(switching_on), .reduced_peak_limit(reduced_peak_limit), .brightness_code(brightness_code),
	.cmd_accepted(cmd_accepted));

// >>> tb/owd_host_model.sv
// Purpose: Host GPIO model of enable and duty pins
// Assumes: Open-drain enable pin with pull-up
// Notes: Each hold starts on a rising edge
`timescale 1ns/100ps
module owd_host_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic host_rel,
	output logic duty_out
);
	// Line held low, duty low at start
	initial begin
		host_rel = 1'b0;
		duty_out = 1'b0;
	end
	// Hold both pins for n cycles
	task automatic drive(input logic r, input logic d, input int n);
		@(posedge clk);
		host_rel <= r;
		duty_out <= d;
		repeat (n - 1) @(posedge clk);
	endtask
	// Raise enable, optionally give the selection pattern
	task automatic power(input logic sel);
		drive(1'b1, 1'b1, 40);
		if (sel) begin
			drive(1'b0, 1'b1, 70);
			drive(1'b1, 1'b1, 1);
		end
	endtask
	// Send n bits, low phase then high phase
	task automatic send(input logic [7:0] a, input logic [15:0] d, input int n, input int k);
		logic [23:0] w;
		w = {d, a};
		for (int i = 0; i < n; i++) begin
			drive(1'b0, 1'b1, w[i] ? k : 3 * k);
			drive(1'b1, 1'b1, w[i] ? 3 * k : k);
		end
		// Short fall ends the last zero bit
		if (n == 24) begin
			drive(1'b0, 1'b1, 5);
			drive(1'b1, 1'b1, 1);
		end
	endtask
endmodule

// >>> tb/test_one_wire_dimming_control.sv
// Purpose: Self-checking bench of owd_top
// Assumes: Counts shortened, bit rates scaled to bit timeout
// Notes: Host pins come from owd_host_model
`timescale 1ns/100ps
module test_one_wire_dimming_control;
	import owd_pkg::*;
	// ====================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic lockout = 1'b1; // Supply low at start
	logic [1:0] fb_gnd = 2'h1; // Sink 0 grounded
	logic host_rel, duty, ctrl_line, ctrl_line_out, ctrl_line_oe;
	logic device_on, onewire_mode, switching_on, reduced_peak_limit, cmd_accepted;
	logic [1:0] chan_enable;
	logic [CODE_W-1:0] brightness_code;
	int error_cnt = 0;
	int samples_checked = 0;
	int ack_cnt = 0; // Cycles device held a released line low
	int acc_cnt = 0; // Accept pulses seen in one command
	// Shortened counts for simulation, ordered unlike the real ones (bit max above window, limit below enable off)
	localparam int unsigned TB_EN_OFF = 200;
	localparam int unsigned TB_DUTY_OFF = 400;
	localparam int unsigned TB_LIMIT = 100;
	localparam int unsigned TB_SEL_WAIT = 20;
	localparam int unsigned TB_SEL_LOW = 50;
	localparam int unsigned TB_SEL_WIN = 200;
	localparam int unsigned TB_BIT_MAX = 300;
	localparam int unsigned TB_ACK = 30;
	int cyc = 0;
	// Open-drain wire with pull-up
	assign ctrl_line = host_rel & (~ctrl_line_oe | ctrl_line_out);
	always #5 clk = ~clk;
	owd_host_model i_owd_host_model (.clk(clk), .host_rel(host_rel), .duty_out(duty));
	owd_top #(.EN_OFF_CYC_P(TB_EN_OFF), .DUTY_OFF_CYC_P(TB_DUTY_OFF), .REDUCED_LIMIT_CYC_P(TB_LIMIT),
		.SELECT_WAIT_CYC_P(TB_SEL_WAIT), .SELECT_LOW_CYC_P(TB_SEL_LOW), .SELECT_WINDOW_CYC_P(TB_SEL_WIN),
		.BIT_MAX_CYC_P(TB_BIT_MAX), .ACK_CYC_P(TB_ACK)) i_owd_top (
		.clk(clk), .rst_n(rst_n), .supply_lockout(lockout), .ctrl_line_in(ctrl_line), .duty_in(duty),
		.sink_feedback_pin_gnd(fb_gnd), .ctrl_line_out(ctrl_line_out), .ctrl_line_oe(ctrl_line_oe),
		.device_on(device_on), .onewire_mode(onewire_mode), .chan_enable(chan_enable),
		.switching_on(switching_on), .reduced_peak_limit(reduced_peak_limit),
		.brightness_code(brightness_code), .cmd_accepted(cmd_accepted));
	// Ack monitor and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (host_rel && ctrl_line === 1'b0) ack_cnt <= ack_cnt + 1;
		if (cmd_accepted === 1'b1) acc_cnt <= acc_cnt + 1;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ====================
	// Tasks
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: code %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	// Settle on falling edges; bounded wait for switching
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_on();
		for (int t = 0; t < 500 && switching_on !== 1'b1; t++) @(negedge clk);
	endtask
	// Frame with zeros in unused bits, then result checks
	task automatic cmd(input logic [7:0] a, input logic [8:0] c, input logic rq, input int n, input int k,
		input logic [8:0] ec, input logic ea);
		ack_cnt = 0;
		acc_cnt = 0;
		i_owd_host_model.send(a, {5'h0, rq, 1'b0, c}, n, k);
		if (n < CMD_BITS) repeat (TB_BIT_MAX + 100) @(posedge clk);
		settle(60);
		chk_code(brightness_code, ec);
		chk_bit(ack_cnt > 0, ea, "ack");
		chk_bit(acc_cnt == ((a == TARGET_ADDRESS_BYTE && n == CMD_BITS) ? 1 : 0), 1'b1, "accept count");
	endtask
	// ====================
	// Tests
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		i_owd_host_model.drive(1'b1, 1'b1, 40);
		settle(1);
		chk_bit(device_on, 1'b0, "on in lockout");
		chk_code(brightness_code, 9'h1FF);
		// Duty drops before lockout lifts, else the filter sees lockout low with both lines high
		i_owd_host_model.drive(1'b1, 1'b0, 10);
		@(posedge clk);
		lockout <= 1'b0;
		i_owd_host_model.drive(1'b1, 1'b0, 40);
		settle(1);
		chk_bit(device_on, 1'b0, "on, duty low");
		$display("Enable conditions done");
		i_owd_host_model.drive(1'b0, 1'b1, 5);
		i_owd_host_model.power(1'b1);
		wait_on();
		chk_bit(onewire_mode, 1'b1, "no one-wire");
		chk_bit(chan_enable === 2'h2, 1'b1, "chan");
		chk_bit(reduced_peak_limit, 1'b1, "no low limit");
		settle(TB_LIMIT + 10);
		chk_bit(reduced_peak_limit, 1'b0, "low limit kept");
		cmd(8'h8F, 9'h155, 1'b1, 24, 4, 9'h155, 1'b1);
		cmd(8'h8F, 9'h0AA, 1'b0, 24, 60, 9'h0AA, 1'b0);
		cmd(8'h8E, 9'h011, 1'b1, 24, 4, 9'h0AA, 1'b0);
		cmd(8'h8F, 9'h033, 1'b0, 12, 4, 9'h0AA, 1'b0);
		cmd(8'h8F, 9'h100, 1'b1, 24, 10, 9'h100, 1'b1);
		$display("Commands done");
		i_owd_host_model.drive(1'b0, 1'b1, TB_EN_OFF + 30);
		settle(2);
		chk_bit(device_on, 1'b0, "ctrl timeout");
		chk_code(brightness_code, 9'h1FF);
		@(posedge clk) fb_gnd <= 2'h0;
		i_owd_host_model.power(1'b0);
		wait_on();
		chk_bit(onewire_mode, 1'b0, "mode kept");
		chk_bit(chan_enable === 2'h3, 1'b1, "chans");
		i_owd_host_model.drive(1'b1, 1'b0, TB_DUTY_OFF + 30);
		settle(2);
		chk_bit(device_on, 1'b0, "duty timeout");
		$display("Shutdown done");
		@(posedge clk) fb_gnd <= 2'h3;
		i_owd_host_model.drive(1'b0, 1'b1, 5);
		i_owd_host_model.power(1'b0);
		settle(TB_SEL_WIN + 100);
		chk_bit(device_on | switching_on, 1'b0, "started grounded");
		$display("Both sinks grounded done");
		report_and_stop();
	end
endmodule
